// ---- include/misc_settings_pkg.sv ----
package misc_settings_pkg;
  // Word-aligned byte addresses of the settings registers.
  localparam logic [4:0] ADR_MISC = 5'h00;
  localparam logic [4:0] ADR_SPECIAL = 5'h04;
  localparam logic [4:0] ADR_WAKE = 5'h08;
  localparam logic [4:0] ADR_SPARE = 5'h0c;
  localparam logic [4:0] ADR_BAND = 5'h10;
  localparam logic [4:0] ADR_STATUS = 5'h14;

  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [7:0] RST_SPECIAL = 8'hc0;
  localparam logic [7:0] RST_WAKE = 8'h40;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [7:0] RST_BAND = 8'h01;

  // Field positions.
  localparam int B_GLOBAL_REPLY = 0;
  localparam int B_COLL_AVOID = 1;
  localparam int B_FORCED_CR = 2;
  localparam int B_TERM_EDIT = 4;
  localparam int B_DCD_CLOCK = 4;
  localparam int B_SHORT_DELAY = 5;
  localparam int B_CTRL_CHAN = 6;
  localparam int B_WAKE_EN = 7;
  localparam int B_MON_LO = 4;

  localparam logic [7:0] CR_BYTE = 8'h0d;
  localparam logic [7:0] GLOBAL_ADR_LO = 8'd240;
  localparam logic [7:0] GLOBAL_ADR_HI = 8'd254;

  localparam logic [3:0] BAND_FORCED = 4'h0;
  localparam logic [3:0] BAND_DEFAULT = 4'h1;
  localparam logic [3:0] BAND_BAD = 4'h2;
  localparam logic [3:0] BAND_LAST = 4'h6;

  localparam logic [1:0] MON_OFF = 2'b00;
  localparam logic [1:0] MON_100K = 2'b01;
  localparam logic [1:0] MON_1M14 = 2'b10;
  localparam logic [1:0] MON_8M = 2'b11;

  localparam int CLK_HZ = 50_000_000;
  localparam int F_100K_HZ = 100_000;
  localparam int F_1M14_HZ = 1_140_000;
  localparam int F_8M_HZ = 8_000_000;
  // Half periods round down, so the rates come out at or above nominal.
  localparam logic [7:0] HALF_100K = 8'(CLK_HZ / (2 * F_100K_HZ));
  localparam logic [7:0] HALF_1M14 = 8'(CLK_HZ / (2 * F_1M14_HZ));
  localparam logic [7:0] HALF_8M = 8'(CLK_HZ / (2 * F_8M_HZ));

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic sel;
    logic [7:0] dat;
  } wb_req_s;
endpackage : misc_settings_pkg

// ---- verilog/mon_clk_div.sv ----
`timescale 1ns/1ns
`default_nettype none
module mon_clk_div (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [7:0] half,
  output logic clk_out
);
  logic [7:0] cnt_q;
  logic out_q;
  wire wrap = (cnt_q >= half - 8'h01);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      out_q <= 1'b0;
    end else if (!en) begin
      cnt_q <= 8'h00;
      out_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= 8'h00;
      out_q <= ~out_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign clk_out = out_q;
endmodule : mon_clk_div
`default_nettype wire

// ---- verilog/modem_misc_settings_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
module modem_misc_settings_bank
  import misc_settings_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire wb_req_s wb_req,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [CNT_W-1:0] interval_cycles,
  input wire logic line_busy,
  input wire logic tx_pending,
  output logic tx_grant,
  output logic cr_strobe,
  output logic [7:0] out_byte,
  input wire logic [7:0] cmd_addr,
  output logic reply_allow,
  input wire logic headerless_mode,
  output logic term_edit_en,
  input wire logic direct_mode,
  output logic short_delay,
  input wire logic dcd_legacy,
  input wire logic dcd_sync_clk,
  output logic dcd_out,
  output logic wake_mode_en,
  output logic listen_lowest_freq,
  output logic monitor_clk,
  output logic [3:0] band_sel,
  output logic band_invalid
);
  logic [7:0] misc_q, special_q, wake_q, spare_q, band_q;
  logic ack_q;
  logic [7:0] rdat_q;
  logic busy_m_q, busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic traffic_q;
  logic [7:0] byte_q;

  // Bus decode.
  wire req = wb_req.cyc && wb_req.stb && !ack_q;
  wire wr = req && wb_req.we && wb_req.sel;
  wire wr_misc = wr && (wb_req.adr == ADR_MISC);
  wire wr_special = wr && (wb_req.adr == ADR_SPECIAL);
  wire wr_wake = wr && (wb_req.adr == ADR_WAKE);
  wire wr_spare = wr && (wb_req.adr == ADR_SPARE);
  wire wr_band = wr && (wb_req.adr == ADR_BAND);

  wire coll_avoid = misc_q[B_COLL_AVOID];
  wire forced_cr = misc_q[B_FORCED_CR];
  wire [3:0] band_raw = band_q[3:0];
  wire [1:0] mon_sel = band_q[B_MON_LO+1:B_MON_LO];

  wire [7:0] status = {band_invalid, traffic_q, busy_q, 1'b0, band_sel};
  wire [7:0] rd_mux =
    (wb_req.adr == ADR_MISC) ? misc_q :
    (wb_req.adr == ADR_SPECIAL) ? special_q :
    (wb_req.adr == ADR_WAKE) ? wake_q :
    (wb_req.adr == ADR_SPARE) ? spare_q :
    (wb_req.adr == ADR_BAND) ? band_q :
    (wb_req.adr == ADR_STATUS) ? status : 8'h00;

  // Defaults on reset.
  // reset defaults
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      misc_q <= RST_MISC;
      special_q <= RST_SPECIAL;
      wake_q <= RST_WAKE;
      spare_q <= RST_SPARE;
      band_q <= RST_BAND;
    end else begin
      if (wr_misc) misc_q <= wb_req.dat;
      if (wr_special) special_q <= wb_req.dat;
      if (wr_wake) wake_q <= wb_req.dat;
      if (wr_spare) spare_q <= wb_req.dat;
      if (wr_band) band_q <= wb_req.dat;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      ack_q <= req;
      rdat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // The line-busy pin is asynchronous to this clock.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_m_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      busy_m_q <= line_busy;
      busy_q <= busy_m_q;
    end
  end

  // Measurement is armed unless avoidance waits for foreign traffic.
  // wait for traffic
  wire armed = !coll_avoid || forced_cr || traffic_q;
  // Reaching or passing the limit both count, so that lowering the interval
  // below the running count cannot stall output for a full counter wrap.
  wire at_limit = (cnt_q >= interval_cycles);
  wire timeout = armed && at_limit && !(coll_avoid && busy_q);

  // A busy line restarts the interval; without avoidance it is ignored.
  // restart on busy
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if ((coll_avoid && busy_q) || timeout) begin
      cnt_q <= '0;
    end else if (!at_limit) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Every interval timeout consumes the seen traffic, with or without output; a new busy cycle wins the clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      traffic_q <= 1'b0;
    end else if (busy_q) begin
      traffic_q <= 1'b1;
    end else if (timeout) begin
      traffic_q <= 1'b0;
    end
  end

  assign tx_grant = coll_avoid ? (timeout && tx_pending) : tx_pending;
  assign cr_strobe = timeout && forced_cr && !tx_pending;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_q <= 8'h00;
    end else if (cr_strobe) begin
      byte_q <= CR_BYTE;
    end
  end
  assign out_byte = byte_q;

  wire is_global = (cmd_addr >= GLOBAL_ADR_LO) && (cmd_addr <= GLOBAL_ADR_HI);
  assign reply_allow = !is_global || misc_q[B_GLOBAL_REPLY];

  assign term_edit_en = headerless_mode && misc_q[B_TERM_EDIT];
  assign short_delay = direct_mode && special_q[B_SHORT_DELAY];
  wire dcd_clk_mode = direct_mode && special_q[B_DCD_CLOCK];
  assign dcd_out = dcd_clk_mode ? dcd_sync_clk : dcd_legacy;
  assign wake_mode_en = wake_q[B_WAKE_EN];
  assign listen_lowest_freq = wake_q[B_WAKE_EN] && wake_q[B_CTRL_CHAN];

  assign band_invalid = (band_raw == BAND_BAD) || (band_raw > BAND_LAST);
  assign band_sel = (band_raw == BAND_FORCED) ? BAND_DEFAULT : band_raw;

  wire [7:0] mon_half =
    (mon_sel == MON_100K) ? HALF_100K :
    (mon_sel == MON_1M14) ? HALF_1M14 : HALF_8M;

  mon_clk_div u_mon_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(mon_sel != MON_OFF),
    .half(mon_half),
    .clk_out(monitor_clk)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_idle_timeout;
    !busy_q && armed && at_limit;
  endsequence

  sequence s_cr_out;
    cr_strobe ##1 (out_byte == CR_BYTE);
  endsequence

  property p_forced_cr;
    (s_idle_timeout and (forced_cr && !tx_pending)) |-> s_cr_out;
  endproperty
  a_forced_cr: assert property (p_forced_cr)
    else $error("no carriage return at interval timeout");

  property p_busy_blocks;
    (coll_avoid && busy_q) |-> !tx_grant && !cr_strobe;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("output while line busy");

  property p_busy_restart;
    (coll_avoid && busy_q) |=> (cnt_q == '0);
  endproperty
  a_busy_restart: assert property (p_busy_restart)
    else $error("interval not restarted by busy line");

  property p_hold_no_traffic;
    (coll_avoid && !forced_cr && !traffic_q) |-> !tx_grant && !cr_strobe;
  endproperty
  a_hold_no_traffic: assert property (p_hold_no_traffic)
    else $error("output before foreign traffic");

  property p_global;
    (cmd_addr >= GLOBAL_ADR_LO && cmd_addr <= GLOBAL_ADR_HI)
      |-> (reply_allow == misc_q[B_GLOBAL_REPLY]);
  endproperty
  a_global: assert property (p_global)
    else $error("global reply gate wrong");

  property p_term;
    !headerless_mode |-> !term_edit_en;
  endproperty
  a_term: assert property (p_term)
    else $error("terminator edit outside headerless mode");

  property p_delay;
    short_delay |-> direct_mode && special_q[B_SHORT_DELAY];
  endproperty
  a_delay: assert property (p_delay)
    else $error("short delay selected wrongly");

  property p_dcd;
    dcd_clk_mode |-> (dcd_out == dcd_sync_clk);
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("carrier detect not driven as clock");

  property p_wake_write;
    (wr_wake && !wb_req.dat[B_WAKE_EN]) |=> !wake_mode_en;
  endproperty
  a_wake_write: assert property (p_wake_write)
    else $error("wake mode on with enable bit clear");

  property p_ctrl_chan;
    listen_lowest_freq |-> wake_q[B_CTRL_CHAN];
  endproperty
  a_ctrl_chan: assert property (p_ctrl_chan)
    else $error("control channel used while disabled");

  property p_mon_off;
    (mon_sel == MON_OFF) [*3] |-> !monitor_clk;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("monitor clock runs while off");

  sequence s_fast_high;
    $rose(monitor_clk) && (mon_sel == MON_8M)
      ##1 (mon_sel == MON_8M) [*2];
  endsequence

  property p_mon_8m;
    s_fast_high |=> $fell(monitor_clk);
  endproperty
  a_mon_8m: assert property (p_mon_8m)
    else $error("fast monitor clock period wrong");

  property p_band;
    (band_raw == BAND_FORCED) |-> (band_sel == BAND_DEFAULT) && !band_invalid;
  endproperty
  a_band: assert property (p_band)
    else $error("band code zero not forced to default");

  property p_reset_vals;
    $fell(rst) |-> misc_q == RST_MISC && special_q == RST_SPECIAL
      && wake_q == RST_WAKE && band_q == RST_BAND;
  endproperty
  a_reset_vals: assert property (@(posedge ref_clk) p_reset_vals)
    else $error("settings not at defaults after reset");
endmodule : modem_misc_settings_bank
`default_nettype wire

// ---- verif/rs485_line_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rs485_line_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic busy_req,
  input wire logic pend_req,
  input wire logic tx_grant,
  output logic line_busy,
  output logic tx_pending
);
  assign line_busy = busy_req;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_pending <= 1'b0;
    end else if (pend_req) begin
      tx_pending <= 1'b1;
    end else if (tx_grant) begin
      tx_pending <= 1'b0;
    end
  end
endmodule : rs485_line_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import misc_settings_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wb_req_s wb_req = '0;
  logic [7:0] wb_dat_o, out_byte, rd, r;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] sh [5];
  logic [15:0] interval_cycles = 16'h0003;
  logic [3:0] band_sel;
  logic headerless_mode = 1'b0, direct_mode = 1'b0, dcd_legacy = 1'b0;
  logic dcd_sync_clk = 1'b0, busy_req = 1'b0, pend_req = 1'b0;
  logic wb_ack_o, tx_grant, cr_strobe, reply_allow, term_edit_en;
  logic short_delay, dcd_out, wake_mode_en, listen_lowest_freq;
  logic monitor_clk, band_invalid, line_busy, tx_pending;
  int num_errors = 0, cmp_count = 0, seed = 56, n, k, iv;
  int fq [4] = '{1, F_100K_HZ, F_1M14_HZ, F_8M_HZ};
  always #10 ref_clk = ~ref_clk;
  modem_misc_settings_bank #(.CNT_W(16)) modem_misc_settings_bank_i (
    .ref_clk, .rst, .wb_req, .wb_dat_o, .wb_ack_o, .interval_cycles,
    .line_busy, .tx_pending, .tx_grant, .cr_strobe, .out_byte, .cmd_addr,
    .reply_allow, .headerless_mode, .term_edit_en, .direct_mode,
    .short_delay, .dcd_legacy, .dcd_sync_clk, .dcd_out, .wake_mode_en,
    .listen_lowest_freq, .monitor_clk, .band_sel, .band_invalid);
  rs485_line_model rs485_line_model_i (.ref_clk, .rst, .busy_req,
    .pend_req, .tx_grant, .line_busy, .tx_pending);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
    int c;
    c = 0;
    wb_req <= '{1'b1, 1'b1, we, a, 1'b1, d};
    do begin
      @(posedge ref_clk);
      c++;
    end while (wb_ack_o !== 1'b1 && c < 50);
    if (c == 50) num_errors++;
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge ref_clk);
  endtask : wb
  // Waits for a grant or a lone carriage return, counting cycles.
  task automatic pulse(input bit g, input int lim, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while ((g ? tx_grant : cr_strobe) !== 1'b1 && c < lim);
  endtask : pulse
  task automatic pend();
    pend_req <= 1'b1;
    @(posedge ref_clk);
    pend_req <= 1'b0;
  endtask : pend
  task automatic defaults();
    sh = '{RST_MISC, RST_SPECIAL, RST_WAKE, RST_SPARE, RST_BAND};
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 5'(i * 4), 8'h00);
      chk(rd, sh[i]);
    end
    wb(1'b0, ADR_STATUS, 8'h00);
    chk(rd, RST_BAND);
  endtask : defaults
  function automatic logic [7:0] legal(int j, logic [7:0] v, logic [3:0] b);
    case (j)
      0: return v & 8'h17;
      1: return 8'hc0 | (v & 8'h30);
      2: return v & 8'hc0;
      3: return 8'h00;
      default: return {2'b00, v[5:4], b};
    endcase
  endfunction : legal
  task automatic check_cfg();
    logic [3:0] b;
    b = sh[4][3:0];
    chk1(reply_allow, !(cmd_addr inside {[8'hf0:8'hfe]}) || sh[0][0]);
    chk1(term_edit_en, headerless_mode & sh[0][4]);
    chk1(short_delay, direct_mode & sh[1][5]);
    chk1(dcd_out, (direct_mode & sh[1][4]) ? dcd_sync_clk : dcd_legacy);
    chk1(wake_mode_en, sh[2][7]);
    chk1(listen_lowest_freq, sh[2][7] & sh[2][6]);
    chk({4'h0, band_sel}, {4'h0, (b == 4'h0) ? 4'h1 : b});
    chk1(band_invalid, b == 4'h2 || b > 4'h6);
  endtask : check_cfg
  task automatic finish_test();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // A hang in the wait for a monitor clock edge ends the run here; bus and pulse waits have their own limits.
  initial begin
    #(20 * 30000);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(out_byte, 8'h00);
    chk1(monitor_clk, 1'b0);
    @(posedge ref_clk);
    defaults();
    wb(1'b1, 5'h1c, 8'hff);
    wb(1'b0, 5'h1c, 8'h00);
    chk(rd, 8'h00);
    // Band nibble walks all sixteen codes, one per five writes.
    for (int i = 0; i < 80; i++) begin
      r = 8'($random(seed));
      k = i % 5;
      sh[k] = legal(k, r, 4'(i / 5));
      cmd_addr <= 8'(236 + (r % 21));
      {headerless_mode, direct_mode, dcd_legacy, dcd_sync_clk} <= r[3:0];
      wb(1'b1, 5'(k * 4), sh[k]);
      wb(1'b0, 5'(k * 4), 8'h00);
      chk(rd, sh[k]);
      #1;
      check_cfg();
      @(posedge ref_clk);
    end
    for (int c = 1; c < 4; c++) begin
      wb(1'b1, ADR_BAND, {2'b00, 2'(c), 4'h1});
      @(posedge monitor_clk);
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (monitor_clk === 1'b1 && n < 300);
      chk(8'(n), 8'(CLK_HZ / (2 * fq[c])));
      @(posedge ref_clk);
    end
    iv = 3 + ($unsigned($random(seed)) % 8);
    interval_cycles <= 16'(iv);
    wb(1'b1, ADR_MISC, 8'h04);
    pulse(1'b0, 100, n);
    #1;
    chk(out_byte, 8'h0d);
    pulse(1'b0, 100, n);
    chk(8'(n), 8'(iv + 1));
    wb(1'b1, ADR_MISC, 8'h06);
    pend();
    pulse(1'b1, 50, n);
    chk1(n < 50, 1'b1);
    busy_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pend();
    pulse(1'b1, 30, n);
    chk(8'(n), 8'h1e);
    busy_req <= 1'b0;
    pulse(1'b1, 40, n);
    chk1(n > iv && n < iv + 7, 1'b1);
    wb(1'b1, ADR_MISC, 8'h02);
    pend();
    pulse(1'b1, 60, n);
    chk(8'(n), 8'h3c);
    busy_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    busy_req <= 1'b0;
    pulse(1'b1, 40, n);
    chk1(n < 40, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    defaults();
    finish_test();
  end
endmodule : tb
`default_nettype wire
